//--- ops_regs.svh
// Purpose: Offsets, field positions, reset values and counter step of the order pair sequencer.
// Assumes: Word-wide register port with byte addresses, each register one aligned word.
// Notes:   Order register digits are numbered 0 (left) to 39 (right).
`ifndef OPS_REGS_SVH
`define OPS_REGS_SVH

`define OPS_REG_AW          8
`define OPS_REG_CTRL        8'h00
`define OPS_REG_COUNTER     8'h04
`define OPS_REG_STATUS      8'h08
`define OPS_REG_ORDER_HI    8'h0C
`define OPS_REG_ORDER_LO    8'h10

`define OPS_CTRL_RUN_BIT    0
`define OPS_CTRL_RST_VAL    1'b1
`define OPS_COUNTER_RST_VAL 10'h000

`define OPS_WORD_W          40
`define OPS_FIELD_W         10
`define OPS_EVEN_ORD_LO     0
`define OPS_EVEN_ORD_HI     9
`define OPS_EVEN_ADR_LO     10
`define OPS_EVEN_ADR_HI     19
`define OPS_ODD_ORD_LO      20
`define OPS_ODD_ORD_HI      29
`define OPS_ODD_ADR_LO      30
`define OPS_ODD_ADR_HI      39

`define OPS_COUNTER_STEP    10'h001

`endif

//--- ops_pkg.sv
// Purpose: Types shared by the order pair sequencer files.
// Assumes: State bits are {A, B, C} in that order.
// Notes:   The encodings follow one another in Gray order along the normal path.
package ops_pkg;

    typedef enum logic [2:0] {
        OPS_FETCH     = 3'h3,
        OPS_EVEN_GATE = 3'h1,
        OPS_EVEN_WAIT = 3'h0,
        OPS_EVEN_EXEC = 3'h4,
        OPS_ODD_WAIT  = 3'h5,
        OPS_ODD_GATE  = 3'h7,
        OPS_ODD_TURN  = 3'h6,
        OPS_ODD_EXEC  = 3'h2
    } ops_state_t;

endpackage : ops_pkg

//--- ops_end_merge.sv
// Purpose: Merges the completion indications of all order types into one end-of-order pulse.
// Assumes: Each source pulses for one cycle when its order type completes.
// Notes:   Completions seen outside an execute phase are dropped.
`timescale 1ns/10ps
module ops_end_merge #(
    parameter int SRCS = 4
) (
    input  wire logic            clock,
    input  wire logic            rst,
    input  wire logic [SRCS-1:0] orderDone,
    input  wire logic            executing,
    output logic                 endOfOrder
);

    wire anyDone;

    initial begin
        if (SRCS < 1) begin
            $error("ops_end_merge needs at least one completion source.");
        end
    end

    assign anyDone = |orderDone;

    // Registered so that the sequencer sees a clean single-cycle event.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            endOfOrder <= 1'b0;
        end else begin
            endOfOrder <= anyDone & executing;
        end
    end

endmodule : ops_end_merge

//--- ops_ctrl_counter.sv
// Purpose: Control counter that names the memory word of the next order pair.
// Assumes: A software load and an increment in the same cycle favour the load.
// Notes:   Wraps around at the top of the address range.
`timescale 1ns/10ps
`include "ops_regs.svh"
module ops_ctrl_counter #(
    parameter int W = `OPS_FIELD_W
) (
    input  wire logic         clock,
    input  wire logic         rst,
    input  wire logic         load,
    input  wire logic [W-1:0] loadValue,
    input  wire logic         step,
    output logic [W-1:0]      count
);

    wire [W-1:0] count_d;

    initial begin
        if (W != `OPS_FIELD_W) begin
            $error("ops_ctrl_counter width must match the address field.");
        end
    end

    assign count_d = load ? loadValue : (step ? count + W'(`OPS_COUNTER_STEP) : count);

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            count <= W'(`OPS_COUNTER_RST_VAL);
        end else begin
            count <= count_d;
        end
    end

endmodule : ops_ctrl_counter

//--- ops_sequencer.sv
// Purpose: Fetches order pairs from memory and issues the even then the odd order.
// Assumes: Memory and execution unit run on the same clock; no control transfer pending.
// Notes:   State flops A, B, C are the sequencing flags and the control-operate flag.
//          Control transfer orders are not decoded: every pair runs even order, then odd.
//          The run bit gates the memory request only; execution already started finishes.
//
// Function
// - Control counter rises by one while a pair is fetched.
// - Order digits 0-9 go to the decoding register as even order.
// - Even order executes before odd order is issued.
// - After even completes, order digits 20-29 go to decoding register.
// - With odd issue, order digits 30-39 are copied into digits 10-19.
// - After odd executes, fetch again from the incremented address.
// - Control-operate flag is 0 during execution, 1 during transfers.
// - Flags A and B step phases and remember even or odd next.
// - In state 011 request memory and accept its clear and gate pulses.
// - Pair transfer finished with no transfer pending sets B to 0.
// - Decoding register loads whole values, needing no prior clear.
// - Operand addresses come from even field; odd address moved there.
// - Dispatch load copies even address field; field also presented outside.
// - Sequencing runs with memory and supervises dispatch counter clear and gate.
// - All order completions merge into one end-of-order signal.
// - States step 011,001,000,100,101,111,110,010 and repeat.
// - Decode-load from even gate, or odd order and address gates together.
// - As execution begins, A takes the opposite of B.
// - Completion of execution returns control-operate flag to 1.
`timescale 1ns/10ps
`include "ops_regs.svh"
module ops_sequencer
    import ops_pkg::*;
#(
    parameter int END_SRCS = 4
) (
    input  wire logic                        clock,
    input  wire logic                        rst,
    input  wire logic [`OPS_REG_AW-1:0]      regAddr,
    input  wire logic [31:0]                 regWrData,
    input  wire logic                        regWrite,
    input  wire logic                        regRead,
    output logic      [31:0]                 regRdData,
    output logic                             useMemory,
    output logic      [`OPS_FIELD_W-1:0]     memAddr,
    input  wire logic                        memClearPulse,
    input  wire logic                        memGatePulse,
    input  wire logic [0:`OPS_WORD_W-1]      memData,
    input  wire logic                        memDone,
    input  wire logic                        opTurnoverEn,
    input  wire logic [END_SRCS-1:0]         orderDone,
    input  wire logic                        dispatchLoadCmd,
    input  wire logic                        dispatchClear,
    output logic      [`OPS_FIELD_W-1:0]     decodingReg,
    output logic      [`OPS_FIELD_W-1:0]     evenAddress,
    output logic      [`OPS_FIELD_W-1:0]     dispatchCounter,
    output logic                             controlOperateFlag,
    output logic                             seqFlagA,
    output logic                             seqFlagB,
    output logic                             evenGateDriver,
    output logic                             oddGateDriver,
    output logic                             execStart
);
    import ops_pkg::*;

    ops_state_t                   state_q;
    ops_state_t                   state_d;
    logic [0:`OPS_WORD_W-1]       orderReg_q;
    logic                         run_q;
    logic                         endOfOrder;
    logic [`OPS_FIELD_W-1:0]      counter;

    wire inFetch;
    wire inEvenGate;
    wire inOddGate;
    wire executing;
    wire oddOrderGate;
    wire oddAddrGate;
    wire decodeLoad;
    wire turnover;
    wire fetchActive;
    wire pairLoaded;
    wire selCtrl;
    wire selCounter;
    wire selStatus;
    wire selOrderHi;
    wire selOrderLo;
    wire counterWrite;
    wire [31:0] statusWord;
    wire [31:0] readMux;
    wire evenGateNext;
    wire oddGateNext;
    wire execEntry;

    initial begin
        if (END_SRCS < 1) begin
            $error("ops_sequencer needs at least one completion source.");
        end
    end

    // Phase decode straight from the A, B, C flops.
    assign inFetch      = (state_q == OPS_FETCH);
    assign inEvenGate   = (state_q == OPS_EVEN_GATE);
    assign inOddGate    = (state_q == OPS_ODD_GATE);
    assign executing    = (state_q == OPS_EVEN_EXEC) || (state_q == OPS_ODD_EXEC);

    // Odd order and odd address gates are driven together but sensed apart.
    assign oddOrderGate = inOddGate;
    assign oddAddrGate  = inOddGate;
    assign decodeLoad   = inEvenGate | (oddOrderGate & oddAddrGate);
    assign turnover     = decodeLoad & opTurnoverEn;

    // Memory pulses are honoured only while this block holds the memory.
    assign fetchActive  = inFetch & useMemory;
    assign pairLoaded   = fetchActive & memDone;

    // Next-cycle view of the gate and execute states feeds the registered outputs.
    assign evenGateNext = (state_d == OPS_EVEN_GATE);
    assign oddGateNext  = (state_d == OPS_ODD_GATE);
    // An execute state is entered only from its interim state, so this lasts one cycle.
    assign execEntry    = ~state_d[0] & (state_d[2] ^ state_d[1]) & ~executing;

    // Register port decode.
    assign selCtrl      = (regAddr == `OPS_REG_CTRL);
    assign selCounter   = (regAddr == `OPS_REG_COUNTER);
    assign selStatus    = (regAddr == `OPS_REG_STATUS);
    assign selOrderHi   = (regAddr == `OPS_REG_ORDER_HI);
    assign selOrderLo   = (regAddr == `OPS_REG_ORDER_LO);
    assign counterWrite = regWrite & selCounter;

    // Unmapped addresses read as zero, so a wider bus can simply OR the slaves.
    assign statusWord   = {4'h0, dispatchCounter, decodingReg, 4'h0,
                           useMemory, seqFlagA, seqFlagB, controlOperateFlag};
    assign readMux      = selCtrl    ? {31'h0000_0000, run_q} :
                          selCounter ? {22'h00_0000, counter} :
                          selStatus  ? statusWord :
                          selOrderHi ? {24'h00_0000, orderReg_q[0:7]} :
                          selOrderLo ? orderReg_q[8:39] :
                                       32'h0000_0000;

    // Next state of the A, B, C flops.
    // Interim states last one cycle; they let C settle before A is turned.
    always_comb begin
        state_d = state_q;
        case (state_q)
            OPS_FETCH: begin
                if (pairLoaded) begin
                    state_d = OPS_EVEN_GATE;
                end
            end
            OPS_EVEN_GATE: begin
                if (turnover) begin
                    state_d = OPS_EVEN_WAIT;
                end
            end
            OPS_EVEN_WAIT: begin
                state_d = ops_state_t'({~state_q[1], state_q[1:0]});
            end
            OPS_EVEN_EXEC: begin
                if (endOfOrder) begin
                    state_d = OPS_ODD_WAIT;
                end
            end
            OPS_ODD_WAIT: begin
                state_d = OPS_ODD_GATE;
            end
            OPS_ODD_GATE: begin
                if (turnover) begin
                    state_d = OPS_ODD_TURN;
                end
            end
            OPS_ODD_TURN: begin
                state_d = ops_state_t'({~state_q[1], state_q[1:0]});
            end
            OPS_ODD_EXEC: begin
                if (endOfOrder) begin
                    state_d = OPS_FETCH;
                end
            end
            default: begin
                state_d = OPS_FETCH;
            end
        endcase
    end

    // The state itself holds the flags, so they can never disagree with it.
    // Reset lands in the fetch state, so a pair transfer is the first work.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            state_q <= OPS_FETCH;
        end else begin
            state_q <= state_d;
        end
    end

    assign seqFlagA           = state_q[2];
    assign seqFlagB           = state_q[1];
    assign controlOperateFlag = state_q[0];

    // Raised from the next state, so the request is up in the first fetch cycle.
    // It drops the cycle after done, so no pulse is honoured past the transfer.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            useMemory <= 1'b0;
        end else begin
            useMemory <= (state_d == OPS_FETCH) & run_q & ~pairLoaded;
        end
    end

    // Gate drivers are registered from the next state, so they track the gate states exactly.
    // The decoding register loads at the end of the first cycle of a gate state.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            evenGateDriver <= 1'b0;
            oddGateDriver  <= 1'b0;
            execStart      <= 1'b0;
        end else begin
            evenGateDriver <= evenGateNext;
            oddGateDriver  <= oddGateNext;
            execStart      <= execEntry;
        end
    end

    // Order register: memory clear and gate pulses during fetch, odd address move later.
    // Repeating the odd address move in every cycle of the odd gate state is harmless.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            orderReg_q <= '0;
        end else if (fetchActive & memGatePulse) begin
            orderReg_q <= memData;
        end else if (fetchActive & memClearPulse) begin
            orderReg_q <= '0;
        end else if (oddAddrGate) begin
            orderReg_q[`OPS_EVEN_ADR_LO:`OPS_EVEN_ADR_HI] <=
                orderReg_q[`OPS_ODD_ADR_LO:`OPS_ODD_ADR_HI];
        end
    end

    assign evenAddress = orderReg_q[`OPS_EVEN_ADR_LO:`OPS_EVEN_ADR_HI];

    // A whole-field load overwrites every digit, so no clear step is needed.
    // The even and odd gate states never overlap, so branch order does not matter.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            decodingReg <= '0;
        end else if (inEvenGate) begin
            decodingReg <= orderReg_q[`OPS_EVEN_ORD_LO:`OPS_EVEN_ORD_HI];
        end else if (oddOrderGate) begin
            decodingReg <= orderReg_q[`OPS_ODD_ORD_LO:`OPS_ODD_ORD_HI];
        end
    end

    // Load has priority; a clear in the same cycle gives way to the fresh address.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            dispatchCounter <= '0;
        end else if (dispatchLoadCmd) begin
            dispatchCounter <= evenAddress;
        end else if (dispatchClear) begin
            dispatchCounter <= '0;
        end
    end

    // The control counter steps on the done pulse, once the pair has landed.
    ops_ctrl_counter #(
        .W         (`OPS_FIELD_W)
    ) u_counter (
        .clock     (clock),
        .rst       (rst),
        .load      (counterWrite),
        .loadValue (regWrData[`OPS_FIELD_W-1:0]),
        .step      (pairLoaded),
        .count     (counter)
    );

    assign memAddr = counter;

    // Completions outside execution are dropped, so a stray pulse cannot skip an order.
    ops_end_merge #(
        .SRCS       (END_SRCS)
    ) u_end_merge (
        .clock      (clock),
        .rst        (rst),
        .orderDone  (orderDone),
        .executing  (executing),
        .endOfOrder (endOfOrder)
    );

    // Software register port: writes land at once, reads answer one cycle later.
    // Clearing run mid-fetch drops the request; the fetch resumes when run returns.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            run_q <= `OPS_CTRL_RST_VAL;
        end else if (regWrite & selCtrl) begin
            run_q <= regWrData[`OPS_CTRL_RUN_BIT];
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            regRdData <= 32'h0000_0000;
        end else begin
            regRdData <= regRead ? readMux : 32'h0000_0000;
        end
    end

endmodule : ops_sequencer

//--- ops_sequencer_asserts.sv
// Purpose: Port-level checks of the order pair sequencer.
// Assumes: One clock domain, reset asynchronous and active high.
// Notes:   The state is read as {seqFlagA, seqFlagB, controlOperateFlag}.
`timescale 1ns/10ps
`include "ops_regs.svh"
module ops_sequencer_asserts #(
    parameter int END_SRCS = 4
) (
    input wire logic                    clock,
    input wire logic                    rst,
    input wire logic                    useMemory,
    input wire logic [`OPS_FIELD_W-1:0] memAddr,
    input wire logic                    memDone,
    input wire logic                    opTurnoverEn,
    input wire logic [END_SRCS-1:0]     orderDone,
    input wire logic                    dispatchLoadCmd,
    input wire logic                    dispatchClear,
    input wire logic [`OPS_FIELD_W-1:0] evenAddress,
    input wire logic [`OPS_FIELD_W-1:0] dispatchCounter,
    input wire logic                    controlOperateFlag,
    input wire logic                    seqFlagA,
    input wire logic                    seqFlagB,
    input wire logic                    evenGateDriver,
    input wire logic                    oddGateDriver,
    input wire logic                    execStart
);
    // Successor of each state, indexed by the state value.
    localparam logic [23:0] NEXT = {3'h6, 3'h2, 3'h7, 3'h5, 3'h1, 3'h3, 3'h0, 3'h4};
    wire logic [2:0] st = {seqFlagA, seqFlagB, controlOperateFlag};
    wire logic       gate = evenGateDriver || oddGateDriver;

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (rst);

    sequence s_gate;
        gate && opTurnoverEn;
    endsequence
    sequence s_exec;
        !controlOperateFlag ##1 (execStart && seqFlagA != seqFlagB);
    endsequence

    property p_turn;
        s_gate |=> s_exec;
    endproperty
    a_turn: assert property (p_turn) else $error("turnover did not start execution");
    property p_hold;
        gate && !opTurnoverEn |=> controlOperateFlag;
    endproperty
    a_hold: assert property (p_hold) else $error("operate entered without enable");
    property p_fetch;
        useMemory |-> st == 3'h3;
    endproperty
    a_fetch: assert property (p_fetch) else $error("memory request outside fetch");
    property p_done;
        useMemory && memDone |=> !useMemory && st == 3'h1 && memAddr == $past(memAddr) + 10'h001;
    endproperty
    a_done: assert property (p_done) else $error("fetch end wrong");
    property p_step;
        st != $past(st) |-> st == NEXT[$past(st)*3 +: 3];
    endproperty
    a_step: assert property (p_step) else $error("illegal state step");
    property p_finish;
        !controlOperateFlag && seqFlagA != seqFlagB && |orderDone |-> ##2 controlOperateFlag;
    endproperty
    a_finish: assert property (p_finish) else $error("control not resumed");
    property p_disp;
        dispatchLoadCmd |=> dispatchCounter == $past(evenAddress);
    endproperty
    a_disp: assert property (p_disp) else $error("dispatch load wrong");
    property p_clr;
        dispatchClear && !dispatchLoadCmd |=> dispatchCounter == 10'h000;
    endproperty
    a_clr: assert property (p_clr) else $error("dispatch clear wrong");
endmodule : ops_sequencer_asserts

bind ops_sequencer ops_sequencer_asserts #(.END_SRCS(END_SRCS)) u_ops_sequencer_asserts (
    .clock, .rst, .useMemory, .memAddr, .memDone, .opTurnoverEn, .orderDone,
    .dispatchLoadCmd, .dispatchClear, .evenAddress, .dispatchCounter,
    .controlOperateFlag, .seqFlagA, .seqFlagB, .evenGateDriver, .oddGateDriver, .execStart);

//--- ops_far_model.sv
// Purpose: Word memory and execution unit facing the sequencer.
// Assumes: Word of address a is {a, ~a, a ^ 2AA, a + 5} from digit 0 on.
// Notes:   With slow set, every answer comes three cycles later.
`timescale 1ns/10ps
module ops_far_model #(
    parameter int SRCS = 4
) (
    input  wire logic        clock,
    input  wire logic        rst,
    input  wire logic        slow,
    input  wire logic        useMemory,
    input  wire logic [9:0]  memAddr,
    input  wire logic        execStart,
    output logic             memClearPulse,
    output logic             memGatePulse,
    output logic      [0:39] memData,
    output logic             memDone,
    output logic [SRCS-1:0]  orderDone
);
    logic [4:0] memCnt_q;
    logic [3:0] exeCnt_q;
    int         src_q;
    wire logic [4:0]  gap = slow ? 5'h3 : 5'h0;
    wire logic [0:39] word = {memAddr, ~memAddr, memAddr ^ 10'h2AA, memAddr + 10'h005};
    wire logic        fire = exeCnt_q == 4'h3 + gap[3:0];

    assign memClearPulse = useMemory && memCnt_q == 5'h1 + gap;
    assign memGatePulse  = useMemory && memCnt_q == 5'h2 + gap;
    assign memDone       = useMemory && memCnt_q == 5'h3 + gap;
    // Off the gate pulse the bus shows the inverse, so a late sample cannot pass.
    assign memData       = memGatePulse ? word : ~word;
    // Each completion comes from the next source in turn.
    assign orderDone     = fire ? SRCS'(1) << src_q : '0;

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            memCnt_q <= 5'h00;
            exeCnt_q <= 4'h0;
            src_q    <= 0;
        end else begin
            memCnt_q <= useMemory ? memCnt_q + 5'h01 : 5'h00;
            if (execStart) begin
                exeCnt_q <= 4'h1;
            end else if (fire) begin
                exeCnt_q <= 4'h0;
                src_q    <= (src_q + 1) % SRCS;
            end else if (exeCnt_q != 4'h0) begin
                exeCnt_q <= exeCnt_q + 4'h1;
            end
        end
    end
endmodule : ops_far_model

//--- order_pair_fetch_sequencer_tb_top.sv
// Purpose: Self-checking bench of the order pair sequencer.
// Assumes: Far side model answers memory and execution traffic.
// Notes:   Register accesses use one-cycle strobes set after a clock edge.
`timescale 1ns/10ps
`include "ops_regs.svh"
`define CHK(what, exp, got) begin checked++; if ((got) !== (exp)) begin fails++; \
    $display("MISMATCH %s expected %0h seen %0h", what, exp, got); end end
module order_pair_fetch_sequencer_tb_top;
    logic clock, rst, regWrite, regRead, opTurnoverEn, dispatchLoadCmd, dispatchClear, slow;
    logic [7:0]  regAddr;
    logic [31:0] regWrData;
    wire logic [31:0] regRdData;
    wire logic [9:0]  memAddr, decodingReg, evenAddress, dispatchCounter;
    wire logic [0:39] memData;
    wire logic [3:0]  orderDone;
    wire logic useMemory, memClearPulse, memGatePulse, memDone, controlOperateFlag;
    wire logic seqFlagA, seqFlagB, evenGateDriver, oddGateDriver, execStart;
    wire logic [2:0]  st = {seqFlagA, seqFlagB, controlOperateFlag};
    int fails, checked, cycles;
    logic [9:0] a;

    ops_sequencer u_ops_sequencer (.clock, .rst, .regAddr, .regWrData, .regWrite, .regRead,
        .regRdData, .useMemory, .memAddr, .memClearPulse, .memGatePulse, .memData, .memDone,
        .opTurnoverEn, .orderDone, .dispatchLoadCmd, .dispatchClear, .decodingReg,
        .evenAddress, .dispatchCounter, .controlOperateFlag, .seqFlagA, .seqFlagB,
        .evenGateDriver, .oddGateDriver, .execStart);
    ops_far_model u_ops_far_model (.clock, .rst, .slow, .useMemory, .memAddr, .execStart,
        .memClearPulse, .memGatePulse, .memData, .memDone, .orderDone);

    initial begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end

    task automatic results;
        $display("checked %0d fails %0d", checked, fails);
        if (fails == 0 && checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : results

    // Ceiling is many times the expected run, so only a hang reaches it.
    always @(posedge clock) begin
        cycles++;
        if (cycles == 3000) begin
            fails++;
            results();
        end
    end

    task automatic regWr(input logic [7:0] ad, input logic [31:0] d);
        @(posedge clock);
        regAddr   <= ad;
        regWrData <= d;
        regWrite  <= 1'b1;
        @(posedge clock);
        regWrite  <= 1'b0;
    endtask : regWr

    task automatic regRd(input logic [7:0] ad, input logic [31:0] exp);
        @(posedge clock);
        regAddr <= ad;
        regRead <= 1'b1;
        @(posedge clock);
        regRead <= 1'b0;
        #1;
        `CHK("regRdData", exp, regRdData)
    endtask : regRd

    task automatic waitFor(input int which);
        logic hit;
        for (int i = 0; i < 100; i++) begin
            @(posedge clock);
            #1;
            hit = (which == 0) ? evenGateDriver : (which == 1) ? oddGateDriver : execStart;
            if (hit === 1'b1) begin
                return;
            end
        end
        fails++;
        $display("MISMATCH wait %0d expected 1 seen 0", which);
    endtask : waitFor

    task automatic pair(input logic [9:0] ad, input logic hold);
        waitFor(0);
        @(posedge clock);
        #1;
        `CHK("decodingReg", ad, decodingReg)
        `CHK("memAddr", ad + 10'h001, memAddr)
        if (hold) begin
            repeat (4) @(posedge clock);
            opTurnoverEn <= 1'b1;
            #1;
            `CHK("state", 3'h1, st)
        end
        waitFor(2);
        `CHK("state", 3'h4, st)
        waitFor(1);
        @(posedge clock);
        #1;
        `CHK("decodingReg", ad ^ 10'h2AA, decodingReg)
        waitFor(2);
        `CHK("evenAddress", ad + 10'h005, evenAddress)
        `CHK("state", 3'h2, st)
    endtask : pair

    initial begin
        rst = 1'b1;
        {regWrite, regRead, dispatchLoadCmd, dispatchClear, slow} = 5'h00;
        opTurnoverEn = 1'b1;
        regAddr = 8'h00;
        regWrData = 32'h0000_0000;
        repeat (11) @(posedge clock);
        #1;
        `CHK("state", 3'h3, st)
        @(posedge clock);
        rst <= 1'b0;
        regRd(`OPS_REG_CTRL, 32'h0000_0001);
        a = 10'h000;
        for (int p = 0; p < 4; p++) begin
            @(posedge clock);
            slow         <= (p == 1);
            opTurnoverEn <= (p != 2);
            pair(a, p == 2);
            if (p == 3) begin
                regWr(`OPS_REG_CTRL, 32'h0000_0000);
            end else if (p == 0) begin
                regWr(`OPS_REG_COUNTER, 32'h0000_03FF);
                a = 10'h3FF;
            end else begin
                a = a + 10'h001;
            end
        end
        repeat (20) @(posedge clock);
        #1;
        `CHK("useMemory", 1'b0, useMemory)
        `CHK("state", 3'h3, st)
        @(posedge clock);
        dispatchLoadCmd <= 1'b1;
        @(posedge clock);
        dispatchLoadCmd <= 1'b0;
        #1;
        `CHK("dispatchCounter", a + 10'h005, dispatchCounter)
        regRd(`OPS_REG_STATUS, {4'h0, a + 10'h005, a ^ 10'h2AA, 8'h03});
        regRd(`OPS_REG_ORDER_HI, {24'h00_0000, a[9:2]});
        regRd(`OPS_REG_ORDER_LO, {a[1:0], a + 10'h005, a ^ 10'h2AA, a + 10'h005});
        regWr(8'h14, 32'hFFFF_FFFF);
        regRd(8'h14, 32'h0000_0000);
        @(posedge clock);
        dispatchClear <= 1'b1;
        @(posedge clock);
        dispatchClear <= 1'b0;
        #1;
        `CHK("dispatchCounter", 10'h000, dispatchCounter)
        results();
    end
endmodule : order_pair_fetch_sequencer_tb_top
